// >>> ccs_pkg.sv
// Purpose: Shared constants and types of the calibration constant command store
// Assumes: 32-bit APB register bus, constants held as signed fixed-point words
// Notes: Register offsets are byte addresses, one aligned word each
package ccs_pkg;

    // ==========================================================
    // Bus widths and register offsets
    localparam int CCS_ADDR_W = 8;
    localparam int CCS_DATA_W = 32;
    localparam logic [7:0] CCS_REG_CMD = 8'h00;
    localparam logic [7:0] CCS_REG_VALUE = 8'h04;
    localparam logic [7:0] CCS_REG_RESULT = 8'h08;
    localparam logic [7:0] CCS_REG_STATUS = 8'h0c;

    // ==========================================================
    // Field layout of the command and status registers
    localparam int CCS_CMD_OP_LSB = 0;
    localparam int CCS_CMD_CHAN_LSB = 8;
    localparam int CCS_CMD_TYPE_LSB = 16;
    localparam int CCS_ST_BUSY = 0;
    localparam int CCS_ST_DONE = 1;
    localparam int CCS_ST_IGN = 2;

    // ==========================================================
    // Channel selector letters and type code ranges
    localparam logic [7:0] CCS_CH_A = 8'h41;
    localparam logic [7:0] CCS_CH_B = 8'h42;
    localparam logic [7:0] CCS_CH_V = 8'h56;
    localparam logic [7:0] CCS_TYPE_LO_MAX = 8'h07;
    localparam logic [7:0] CCS_TYPE_HI_MIN = 8'h0a;
    localparam logic [7:0] CCS_TYPE_HI_MAX = 8'h0d;
    localparam logic [3:0] CCS_TYPE_GAP = 4'h2;
    localparam logic [5:0] CCS_BASE_A = 6'h00;
    localparam logic [5:0] CCS_BASE_B = 6'h0c;
    localparam logic [5:0] CCS_BASE_V = 6'h18;
    localparam int CCS_NUM_ENTRY = 36;
    localparam logic [5:0] CCS_LAST_ENTRY = 6'h23;

    // ==========================================================
    // Reset values of the constants (gain in units of 1e-5)
    localparam logic [31:0] CCS_GAIN_ONE = 32'h000186a0;
    localparam logic [31:0] CCS_OFFSET_ZERO = 32'h00000000;

    // ==========================================================
    // Command codes written to the command register
    typedef enum logic [3:0] {
        CCS_OP_NONE = 4'h0,
        CCS_OP_SET_GAIN = 4'h1,
        CCS_OP_QUERY_GAIN = 4'h2,
        CCS_OP_RAW_READ = 4'h3,
        CCS_OP_RESET_GAIN = 4'h4,
        CCS_OP_RESET_OFFSET = 4'h5,
        CCS_OP_COMMIT = 4'h6,
        CCS_OP_SET_OFFSET = 4'h7,
        CCS_OP_QUERY_OFFSET = 4'h8
    } ccs_op_t;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        CCS_IDLE = 2'b01,
        CCS_SAVE = 2'b10
    } ccs_fsm_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [CCS_ADDR_W-1:0] paddr;
        logic [CCS_DATA_W-1:0] pwdata;
    } ccs_apb_req_t;

    // Nonvolatile store write port: bank 0 offsets, bank 1 gains
    typedef struct packed {
        logic req;
        logic bank;
        logic [5:0] entry;
        logic [31:0] data;
    } ccs_nvm_t;

endpackage

// >>> ccs_cmd_decode.sv
// Purpose: Check channel selector and type code and form the constant table index
// Assumes: Selector is an ASCII letter, type is a binary code
// Notes: Purely combinational
`timescale 1ns/1ps
module ccs_cmd_decode (
    input wire logic [7:0] chan_in,
    input wire logic [7:0] type_in,
    output logic valid_out,
    output logic sensor_out,
    output logic [5:0] index_out
);
    import ccs_pkg::*;

    logic chan_ok;
    logic type_ok;
    logic [5:0] base;
    logic [3:0] tidx;

    always_comb begin
        chan_ok = 1'b1;
        base = CCS_BASE_A;
        sensor_out = 1'b1;
        unique case (chan_in)
            CCS_CH_A: base = CCS_BASE_A;
            CCS_CH_B: base = CCS_BASE_B;
            CCS_CH_V: begin
                base = CCS_BASE_V;
                sensor_out = 1'b0;
            end
            default: begin
                chan_ok = 1'b0;
                sensor_out = 1'b0;
            end
        endcase
        // Codes 8 and 9 are holes; the upper range packs down after 7
        type_ok = (type_in <= CCS_TYPE_LO_MAX) ||
            ((type_in >= CCS_TYPE_HI_MIN) && (type_in <= CCS_TYPE_HI_MAX));
        tidx = (type_in <= CCS_TYPE_LO_MAX) ? type_in[3:0] : type_in[3:0] - CCS_TYPE_GAP;
        valid_out = chan_ok && type_ok;
        index_out = base + {2'b00, tidx};
    end

endmodule

// >>> ccs_store.sv
// Purpose: Calibration constant command store behind an APB slave
// Assumes: Readings and the nonvolatile store controller run on sys_clk_in
// Notes: One wait state on every APB access
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module ccs_store #(
    parameter logic [31:0] GAIN_DEFAULT = ccs_pkg::CCS_GAIN_ONE
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire ccs_pkg::ccs_apb_req_t apb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [31:0] reading_a_in,
    input wire logic [31:0] reading_b_in,
    output ccs_pkg::ccs_nvm_t nvm_out,
    input wire logic nvm_ack_in
);
    import ccs_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [CCS_NUM_ENTRY-1:0][31:0] offs;
        logic [CCS_NUM_ENTRY-1:0][31:0] gain;
        ccs_fsm_t fsm;
        logic [31:0] cmd;
        logic [31:0] value;
        logic [31:0] result;
        logic done;
        logic ign;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        ccs_nvm_t nvm;
    } ccs_state_t;

    ccs_state_t state_reg;
    ccs_state_t state_next;
    logic [1:0] rst_sync_reg;
    logic rst_b;
    logic access;
    logic commit;
    logic dec_valid;
    logic dec_sensor;
    logic [5:0] dec_index;
    ccs_op_t op;
    logic [31:0] status_word;

    // ==========================================================
    // Reset release
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_reg[1];

    // ==========================================================
    // Command field decode
    ccs_cmd_decode u_decode (
        .chan_in(apb_in.pwdata[CCS_CMD_CHAN_LSB +: 8]),
        .type_in(apb_in.pwdata[CCS_CMD_TYPE_LSB +: 8]),
        .valid_out(dec_valid),
        .sensor_out(dec_sensor),
        .index_out(dec_index)
    );

    assign access = apb_in.psel && apb_in.penable;
    // Writes take effect only at the edge that completes the access
    assign commit = access && state_reg.pready;
    assign op = ccs_op_t'(apb_in.pwdata[CCS_CMD_OP_LSB +: 4]);

    always_comb begin
        status_word = 32'h00000000;
        status_word[CCS_ST_BUSY] = (state_reg.fsm == CCS_SAVE);
        status_word[CCS_ST_DONE] = state_reg.done;
        status_word[CCS_ST_IGN] = state_reg.ign;
    end

    // ==========================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;

        if (access && !state_reg.pready) begin
            state_next.pready = 1'b1;
            state_next.prdata = 32'h00000000;
            unique case (apb_in.paddr)
                CCS_REG_CMD: state_next.prdata = state_reg.cmd;
                CCS_REG_VALUE: state_next.prdata = state_reg.value;
                CCS_REG_RESULT: state_next.prdata = state_reg.result;
                CCS_REG_STATUS: state_next.prdata = status_word;
                default: state_next.pslverr = 1'b1;
            endcase
        end

        // Clears first so that a same-cycle event below wins
        if (commit && apb_in.pwrite && apb_in.paddr == CCS_REG_STATUS) begin
            if (apb_in.pwdata[CCS_ST_DONE]) begin
                state_next.done = 1'b0;
            end
            if (apb_in.pwdata[CCS_ST_IGN]) begin
                state_next.ign = 1'b0;
            end
        end

        if (commit && apb_in.pwrite && apb_in.paddr == CCS_REG_VALUE) begin
            state_next.value = apb_in.pwdata;
        end

        if (commit && apb_in.pwrite && apb_in.paddr == CCS_REG_CMD) begin
            state_next.cmd = apb_in.pwdata;
            if (state_reg.fsm == CCS_SAVE) begin
                // Table is being copied out; refuse rather than tear it
                state_next.ign = 1'b1;
            end else begin
                unique case (op)
                    CCS_OP_COMMIT: begin
                        state_next.fsm = CCS_SAVE;
                        state_next.nvm.req = 1'b1;
                        state_next.nvm.bank = 1'b0;
                        state_next.nvm.entry = 6'h00;
                        state_next.nvm.data = state_reg.offs[0];
                    end
                    CCS_OP_RAW_READ: begin
                        if (dec_sensor) begin
                            state_next.result = (apb_in.pwdata[CCS_CMD_CHAN_LSB +: 8] == CCS_CH_A)
                                ? reading_a_in : reading_b_in;
                            state_next.done = 1'b1;
                        end else begin
                            state_next.ign = 1'b1;
                        end
                    end
                    CCS_OP_SET_GAIN, CCS_OP_QUERY_GAIN, CCS_OP_RESET_GAIN,
                    CCS_OP_RESET_OFFSET, CCS_OP_SET_OFFSET, CCS_OP_QUERY_OFFSET: begin
                        if (!dec_valid) begin
                            state_next.ign = 1'b1;
                        end else begin
                            state_next.done = 1'b1;
                            unique case (op)
                                CCS_OP_SET_GAIN:
                                    state_next.gain[dec_index] = state_reg.value;
                                CCS_OP_QUERY_GAIN:
                                    state_next.result = state_reg.gain[dec_index];
                                CCS_OP_RESET_GAIN:
                                    state_next.gain[dec_index] = GAIN_DEFAULT;
                                CCS_OP_RESET_OFFSET:
                                    state_next.offs[dec_index] = CCS_OFFSET_ZERO;
                                CCS_OP_SET_OFFSET:
                                    state_next.offs[dec_index] = state_reg.value;
                                default:
                                    state_next.result = state_reg.offs[dec_index];
                            endcase
                        end
                    end
                    default: state_next.ign = 1'b1;
                endcase
            end
        end

        // Copy-out walk: offsets bank first, then gains, one word per handshake
        unique case (state_reg.fsm)
            CCS_IDLE: begin
            end
            CCS_SAVE: begin
                if (state_reg.nvm.req && nvm_ack_in) begin
                    if (state_reg.nvm.entry != CCS_LAST_ENTRY) begin
                        state_next.nvm.entry = state_reg.nvm.entry + 6'h01;
                        state_next.nvm.data = state_reg.nvm.bank
                            ? state_reg.gain[state_reg.nvm.entry + 6'h01]
                            : state_reg.offs[state_reg.nvm.entry + 6'h01];
                    end else if (!state_reg.nvm.bank) begin
                        state_next.nvm.bank = 1'b1;
                        state_next.nvm.entry = 6'h00;
                        state_next.nvm.data = state_reg.gain[0];
                    end else begin
                        state_next.nvm.req = 1'b0;
                        state_next.fsm = CCS_IDLE;
                        state_next.done = 1'b1;
                    end
                end
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk_in or negedge rst_b) begin
        if (!rst_b) begin
            state_reg.offs <= {CCS_NUM_ENTRY{CCS_OFFSET_ZERO}};
            state_reg.gain <= {CCS_NUM_ENTRY{GAIN_DEFAULT}};
            state_reg.fsm <= CCS_IDLE;
            state_reg.cmd <= 32'h00000000;
            state_reg.value <= 32'h00000000;
            state_reg.result <= 32'h00000000;
            state_reg.done <= 1'b0;
            state_reg.ign <= 1'b0;
            state_reg.pready <= 1'b0;
            state_reg.pslverr <= 1'b0;
            state_reg.prdata <= 32'h00000000;
            state_reg.nvm <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata_out = state_reg.prdata;
    assign pready_out = state_reg.pready;
    assign pslverr_out = state_reg.pslverr;
    assign nvm_out = state_reg.nvm;

endmodule

// >>> ccs_store_assertions.sv
// Purpose: Concurrent checks on the ports of the constant command store
// Assumes: One clock domain, reset active low
// Notes: Bound to ccs_store from the testbench file
`timescale 1ns/1ps
module ccs_store_assertions import ccs_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire ccs_pkg::ccs_apb_req_t apb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [31:0] reading_a_in,
    input wire logic [31:0] reading_b_in,
    input wire ccs_pkg::ccs_nvm_t nvm_out,
    input wire logic nvm_ack_in
);
    import ccs_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // ==========================================================
    // Bus answer
    property p_wait_state;
        apb_in.psel && apb_in.penable && !pready_out |=> pready_out;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("no answer after one wait");
    property p_ready_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    property p_slverr;
        pready_out |-> pslverr_out == (apb_in.paddr > 8'h0c || apb_in.paddr[1:0] != 2'h0);
    endproperty
    a_slverr: assert property (p_slverr) else $error("error flag wrong for address");
    property p_unmapped_zero;
        pready_out && pslverr_out && !apb_in.pwrite |-> prdata_out == 32'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    // ==========================================================
    // Save sequence
    property p_commit_start;
        apb_in.psel && apb_in.penable && pready_out && apb_in.pwrite && apb_in.paddr == 8'h00
            && apb_in.pwdata[3:0] == 4'h6 && !nvm_out.req
            |=> nvm_out.req && !nvm_out.bank && nvm_out.entry == 6'h00;
    endproperty
    a_commit_start: assert property (p_commit_start) else $error("save did not start");
    property p_nvm_hold;
        nvm_out.req && !nvm_ack_in |=> nvm_out.req && $stable(nvm_out);
    endproperty
    a_nvm_hold: assert property (p_nvm_hold) else $error("store word changed unacked");
    property p_nvm_step;
        nvm_out.req && nvm_ack_in && nvm_out.entry != CCS_LAST_ENTRY |=> nvm_out.req
            && nvm_out.entry == $past(nvm_out.entry) + 6'h01 && nvm_out.bank == $past(nvm_out.bank);
    endproperty
    a_nvm_step: assert property (p_nvm_step) else $error("store entry did not advance");
    property p_nvm_bank;
        nvm_out.req && nvm_ack_in && nvm_out.entry == CCS_LAST_ENTRY && !nvm_out.bank
            |=> nvm_out.req && nvm_out.bank && nvm_out.entry == 6'h00;
    endproperty
    a_nvm_bank: assert property (p_nvm_bank) else $error("gain bank not started");
    property p_nvm_end;
        nvm_out.req && nvm_ack_in && nvm_out.entry == CCS_LAST_ENTRY && nvm_out.bank |=> !nvm_out.req;
    endproperty
    a_nvm_end: assert property (p_nvm_end) else $error("save did not stop");
endmodule

// >>> ccs_nvm_model.sv
// Purpose: Nonvolatile store on the far side of the save port
// Assumes: Same clock as the store
// Notes: Slow mode accepts one word every third cycle to stress the hold logic
`timescale 1ns/1ps
module ccs_nvm_model import ccs_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire ccs_pkg::ccs_nvm_t nvm_in,
    input wire logic slow_in,
    output logic ack_out
);
    import ccs_pkg::*;
    logic [1:0] wait_reg;
    logic [7:0] count;
    logic [31:0] off_mem [36];
    logic [31:0] gain_mem [36];
    assign ack_out = nvm_in.req && (!slow_in || wait_reg == 2'h2);
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wait_reg <= 2'h0;
            count <= 8'h00;
        end else begin
            wait_reg <= (ack_out || !nvm_in.req) ? 2'h0 : wait_reg + 2'h1;
            if (ack_out) begin
                if (nvm_in.bank) gain_mem[nvm_in.entry] <= nvm_in.data;
                else off_mem[nvm_in.entry] <= nvm_in.data;
                count <= count + 8'h01;
            end
        end
    end
endmodule

// >>> ccs_tb.sv
// Purpose: Self-checking bench for the constant command store
// Assumes: Design answers every access with one wait state
// Notes: Expected table is kept in the bench and compared after each save
`timescale 1ns/1ps
module testbench;
    import ccs_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic slow = 1'b0;
    logic ack, pready, pslverr, err;
    logic [31:0] prdata, rd, v;
    logic [31:0] ra = 32'hfff0bdc0;
    logic [31:0] rb = 32'h0001e240;
    ccs_apb_req_t apb = '0;
    ccs_nvm_t nvm;
    int n_errors = 0;
    int n_compared = 0;
    int k, saves = 0;
    longint g, negative_full_scale_reading, positive_full_scale_reading;
    logic [31:0] exp_off [36];
    logic [31:0] exp_gain [36];
    logic [7:0] chs [3] = '{CCS_CH_A, CCS_CH_B, CCS_CH_V};
    logic [7:0] tys [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h0a, 8'h0b, 8'h0c, 8'h0d};
    logic [7:0] bad_ch [5] = '{8'h43, CCS_CH_A, CCS_CH_A, CCS_CH_B, CCS_CH_V};
    logic [7:0] bad_ty [5] = '{8'h02, 8'h08, 8'h09, 8'h0e, 8'hff};
    always #10 sys_clk_in = ~sys_clk_in;
    ccs_store uut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .apb_in(apb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .reading_a_in(ra), .reading_b_in(rb), .nvm_out(nvm), .nvm_ack_in(ack));
    ccs_nvm_model nvm_m (.clk_in(sys_clk_in), .rst_b_in(rst_b_in), .nvm_in(nvm),
        .slow_in(slow), .ack_out(ack));
    task summarize;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // ==========================================================
    // Bus access: request held until ready is seen at a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk_in);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk_in);
        apb.penable <= 1'b1;
        i = 0;
        do begin
            @(posedge sys_clk_in);
            i++;
        end while (pready !== 1'b1 && i < 50);
        rd = prdata;
        err = pslverr;
        apb <= '0;
        if (i >= 50) begin
            n_errors++;
            summarize;
        end
    endtask
    task cmd(input ccs_op_t op, input logic [7:0] ch, input logic [7:0] ty);
        bus(1'b1, CCS_REG_CMD, {8'h00, ty, ch, 4'h0, op});
    endtask
    task query(input ccs_op_t op, input logic [7:0] ch, input logic [7:0] ty);
        cmd(op, ch, ty);
        bus(1'b0, CCS_REG_RESULT, 32'h0);
    endtask
    task verify_all;
        for (int c = 0; c < 3; c++) begin
            for (int t = 0; t < 12; t++) begin
                k = c * 12 + t;
                query(CCS_OP_QUERY_GAIN, chs[c], tys[t]);
                chk(rd, exp_gain[k]);
                query(CCS_OP_QUERY_OFFSET, chs[c], tys[t]);
                chk(rd, exp_off[k]);
            end
        end
    endtask
    task ign_seen;
        bus(1'b0, CCS_REG_STATUS, 32'h0);
        chk(32'(rd[CCS_ST_IGN]), 32'h1);
        bus(1'b1, CCS_REG_STATUS, 32'h4);
    endtask
    task commit;
        int i;
        cmd(CCS_OP_COMMIT, 8'h00, 8'h00);
        saves++;
        if (slow) begin
            // Constants must not change while the table is being copied out
            cmd(CCS_OP_RESET_GAIN, CCS_CH_A, 8'h00);
            ign_seen;
        end
        i = 0;
        do begin
            bus(1'b0, CCS_REG_STATUS, 32'h0);
            i++;
        end while (rd[CCS_ST_BUSY] !== 1'b0 && i < 200);
        if (i >= 200) begin
            n_errors++;
            summarize;
        end
        chk(32'(rd[CCS_ST_DONE]), 32'h1);
        chk(32'(nvm_m.count), 32'(saves * 72));
        for (int j = 0; j < 36; j++) begin
            chk(nvm_m.off_mem[j], exp_off[j]);
            chk(nvm_m.gain_mem[j], exp_gain[j]);
        end
        bus(1'b1, CCS_REG_STATUS, 32'h6);
    endtask
    task restart;
        rst_b_in <= 1'b0;
        repeat (12) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        for (int j = 0; j < 36; j++) begin
            exp_off[j] = CCS_OFFSET_ZERO;
            exp_gain[j] = CCS_GAIN_ONE;
        end
    endtask
    initial begin
        restart;
        verify_all;
        for (int c = 0; c < 3; c++) begin
            for (int t = 0; t < 12; t++) begin
                k = c * 12 + t;
                v = {8'h80, chs[c], tys[t], 8'h5a};
                exp_gain[k] = v;
                exp_off[k] = ~v;
                bus(1'b1, CCS_REG_VALUE, v);
                cmd(CCS_OP_SET_GAIN, chs[c], tys[t]);
                bus(1'b1, CCS_REG_VALUE, ~v);
                cmd(CCS_OP_SET_OFFSET, chs[c], tys[t]);
            end
        end
        verify_all;
        commit;
        cmd(CCS_OP_RESET_GAIN, CCS_CH_A, 8'h02);
        exp_gain[2] = CCS_GAIN_ONE;
        cmd(CCS_OP_RESET_OFFSET, CCS_CH_B, 8'h0d);
        exp_off[23] = CCS_OFFSET_ZERO;
        bus(1'b1, CCS_REG_VALUE, 32'h12345678);
        for (int j = 0; j < 5; j++) begin
            cmd(CCS_OP_SET_GAIN, bad_ch[j], bad_ty[j]);
            ign_seen;
            cmd(CCS_OP_RESET_OFFSET, bad_ch[j], bad_ty[j]);
            ign_seen;
        end
        cmd(ccs_op_t'(4'hf), CCS_CH_A, 8'h00);
        ign_seen;
        verify_all;
        query(CCS_OP_RAW_READ, CCS_CH_A, 8'h00);
        chk(rd, ra);
        // A fresh reading must be returned, not the one captured before
        ra <= 32'h00054321;
        query(CCS_OP_RAW_READ, CCS_CH_A, 8'h00);
        chk(rd, 32'h00054321);
        query(CCS_OP_RAW_READ, CCS_CH_B, 8'h00);
        chk(rd, rb);
        cmd(CCS_OP_RAW_READ, CCS_CH_V, 8'h00);
        ign_seen;
        bus(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        bus(1'b1, 8'h06, 32'h0);
        chk(32'(err), 32'h1);
        // Output calibration as the host performs it, readings in units of 1e-6
        cmd(CCS_OP_RESET_OFFSET, CCS_CH_V, 8'h01);
        cmd(CCS_OP_RESET_GAIN, CCS_CH_V, 8'h01);
        exp_off[25] = CCS_OFFSET_ZERO;
        exp_gain[25] = CCS_GAIN_ONE;
        negative_full_scale_reading = -64'sd1005640;
        g = -((negative_full_scale_reading / 10) + 100000);
        exp_off[25] = 32'(g);
        bus(1'b1, CCS_REG_VALUE, exp_off[25]);
        cmd(CCS_OP_SET_OFFSET, CCS_CH_V, 8'h01);
        positive_full_scale_reading = 64'sd1004320;
        g = 64'sd2000000 * 100000
            / (positive_full_scale_reading - negative_full_scale_reading);
        chk(32'(g > 95000 && g < 105000), 32'h1);
        exp_gain[25] = 32'(g);
        bus(1'b1, CCS_REG_VALUE, exp_gain[25]);
        cmd(CCS_OP_SET_GAIN, CCS_CH_V, 8'h01);
        verify_all;
        slow <= 1'b1;
        commit;
        // Reset in mid-run must bring every constant back to its default
        restart;
        verify_all;
        summarize;
    end
endmodule
bind ccs_store ccs_store_assertions chk_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .apb_in(apb_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .reading_a_in(reading_a_in), .reading_b_in(reading_b_in),
    .nvm_out(nvm_out), .nvm_ack_in(nvm_ack_in));
